// ---- ssc_bc_if.sv ----
/*
  Carrier between the top block and one back-channel pin unpacker.
  Assumes the top drives the frame fields and reads the pin levels.
*/
`timescale 1ns/100ps
interface ssc_bc_if;
  logic frame_valid;
  logic crc_ok;
  ssc_pkg::ssc_payload_type payload;
  logic [2:0] mode;
  logic [1:0] rate;
  logic [3:0] pins;
  modport src (output frame_valid, crc_ok, payload, mode, rate,
               input pins);
  modport unp (input frame_valid, crc_ok, payload, mode, rate,
               output pins);
endinterface

// ---- ssc_bc_unpack.sv ----
/*
  Back-channel pin unpacker: spreads the pin samples of one frame over the
  frame time, one sample every gap, in the three fast sampling modes; normal mode applies its single sample at once.
  Assumes one frame strobe per frame, synchronous to clk.
*/
`timescale 1ns/100ps
module ssc_bc_unpack (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_down_bar,
  ssc_bc_if.unp bc
);
  import ssc_pkg::*;
  `include "ssc_cfg.svh"

  // ----------------------------------------------------------------------
  // mode helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] width_of(input logic [2:0] m);
    case (m)
      `SSC_MODE_F2: width_of = 3'h2;
      `SSC_MODE_F1: width_of = 3'h1;
      default: width_of = 3'h4;
    endcase
  endfunction

  function automatic logic [3:0] count_of(input logic [2:0] m);
    case (m)
      `SSC_MODE_F4: count_of = 4'h6;
      `SSC_MODE_F2: count_of = 4'ha;
      `SSC_MODE_F1: count_of = 4'hf;
      default: count_of = 4'h1;
    endcase
  endfunction

  // narrow modes only refresh the pins they carry
  function automatic logic [3:0] apply(input logic [2:0] m,
                                       input logic [3:0] p,
                                       input ssc_payload_type s);
    case (m)
      `SSC_MODE_F2: apply = {p[3:2], s[1:0]};
      `SSC_MODE_F1: apply = {p[3:1], s[0]};
      default: apply = s[3:0];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // sample sequencer
  // ----------------------------------------------------------------------
  ssc_unp_state_type state_ff, nxt_state;
  ssc_payload_type shift_ff, nxt_shift;
  logic [3:0] left_ff, nxt_left;
  logic [7:0] gap_ff, nxt_gap;
  logic [3:0] pins_ff, nxt_pins;
  logic [2:0] mode_ff, nxt_mode;
  logic [7:0] gap_cyc;
  logic mode_ok;

  // faster line rates shorten the sample gap
  assign gap_cyc = 8'(`SSC_BC_GAP_CYC) >> bc.rate;
  assign mode_ok = bc.mode <= `SSC_MODE_F4;
  assign bc.pins = pins_ff;

  // next-state: new frame restarts, otherwise step on gap expiry
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_left = left_ff;
    nxt_gap = gap_ff;
    nxt_pins = pins_ff;
    nxt_mode = mode_ff;
    if (!power_down_bar) begin
      nxt_state = SSC_IDLE;
      nxt_pins = 4'h0;
    end else if (bc.frame_valid && bc.crc_ok && mode_ok) begin
      nxt_mode = bc.mode;
      nxt_pins = apply(bc.mode, pins_ff, bc.payload);
      nxt_shift = bc.payload >> width_of(bc.mode);
      nxt_left = count_of(bc.mode) - 4'h1;
      nxt_gap = gap_cyc;
      nxt_state = (nxt_left != 4'h0) ? SSC_RUN : SSC_IDLE;
    end else begin
      case (state_ff)
        SSC_RUN: begin
          if (gap_ff <= 8'h1) begin
            nxt_pins = apply(mode_ff, pins_ff, shift_ff);
            nxt_shift = shift_ff >> width_of(mode_ff);
            nxt_left = left_ff - 4'h1;
            nxt_gap = gap_cyc;
            if (left_ff == 4'h1) begin
              nxt_state = SSC_IDLE;
            end
          end else begin
            nxt_gap = gap_ff - 8'h1;
          end
        end
        default: nxt_state = SSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SSC_IDLE;
      shift_ff <= '0;
      left_ff <= 4'h0;
      gap_ff <= 8'h0;
      pins_ff <= 4'h0;
      mode_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      left_ff <= nxt_left;
      gap_ff <= nxt_gap;
      pins_ff <= nxt_pins;
      mode_ff <= nxt_mode;
    end
  end
endmodule

// ---- ssc_cfg.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  serializer sideband control block.
  Assumes a 50 MHz clock; included by its bare name.
*/
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// ------------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------------
`define SSC_ADR_LINK 8'h0c
`define SSC_ADR_PIN0 8'h0d
`define SSC_ADR_PIN12 8'h0e
`define SSC_ADR_PIN3 8'h0f
`define SSC_ADR_PSEL 8'h1e
`define SSC_ADR_BCST 8'h1f
`define SSC_ADR_ICTL 8'hc6
`define SSC_ADR_ISTS 8'hc7

// ------------------------------------------------------------------------
// field positions and codes
// ------------------------------------------------------------------------
`define SSC_PSEL_SAE 2
`define SSC_ICTL_GLB 0
`define SSC_ICTL_LNK 1
`define SSC_ICTL_REM 5
`define SSC_PIN_FWD 4'h3
`define SSC_PIN_BACK 4'h5
`define SSC_MODE_NORM 3'h0
`define SSC_MODE_F1 3'h1
`define SSC_MODE_F2 3'h2
`define SSC_MODE_F4 3'h3

// ------------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------------
`define SSC_RST_PSEL 8'h01
`define SSC_RST_PIN 8'h00
`define SSC_RST_ICTL 8'h00

// ------------------------------------------------------------------------
// timing
// ------------------------------------------------------------------------
`define SSC_CLK_NS 20
`define SSC_BC_BIT_NS 200
`define SSC_BC_BIT_CYC (`SSC_BC_BIT_NS / `SSC_CLK_NS)
`define SSC_BC_GAP_BITS 4
`define SSC_BC_GAP_CYC (`SSC_BC_BIT_CYC * `SSC_BC_GAP_BITS)
`define SSC_PD_HOLD_MS 3

`endif

// ---- ssc_des_model.sv ----
/*
  Far-end model: paired deserializer as seen by the sideband block.
  Assumes clk is the block clock; the bench drives it through tasks.
*/
`timescale 1ns/100ps
module ssc_des_model (
  input wire logic clk,
  output logic remote_irq_in_n,
  output logic [1:0] lane_link_ok,
  output logic [1:0] lane_fault,
  output logic [1:0] bc_frame_valid,
  output logic [1:0] bc_crc_ok,
  output ssc_pkg::ssc_payload_type bc_payload0,
  output ssc_pkg::ssc_payload_type bc_payload1,
  output logic [2:0] bc_mode,
  output logic [1:0] bc_rate
);
  import ssc_pkg::*;
  // ----------
  // idle state
  // ----------
  // irq released, both lanes linked, no frames
  initial begin
    remote_irq_in_n = 1'b1;
    lane_link_ok = 2'b11;
    lane_fault = 2'b00;
    bc_frame_valid = 2'b00;
    bc_crc_ok = 2'b00;
    bc_payload0 = 24'h000000;
    bc_payload1 = 24'h000000;
    bc_mode = 3'h0;
    bc_rate = 2'h0;
  end
  // ----------
  // actions
  // ----------
  // pin field on this side is the complement of the serializer's
  function automatic logic [3:0] des_pin(input logic [3:0] s);
    return (s == 4'h3) ? 4'h5 : 4'h3;
  endfunction
  // sampling mode and line rate are chosen on this side
  task automatic set_mode(input logic [2:0] m, input logic [1:0] r);
    @(posedge clk);
    bc_mode <= m;
    bc_rate <= r;
  endtask
  // one good frame; payload goes to its inverse once released
  task automatic send_frame(input logic lane, input ssc_payload_type p);
    @(posedge clk);
    bc_frame_valid[lane] <= 1'b1;
    bc_crc_ok[lane] <= 1'b1;
    bc_payload0 <= p;
    bc_payload1 <= p;
    @(posedge clk);
    bc_frame_valid[lane] <= 1'b0;
    bc_crc_ok[lane] <= 1'b0;
    bc_payload0 <= ~p;
    bc_payload1 <= ~p;
  endtask
  // frame with a failed check: crc flag stays low, block must drop it
  task automatic send_bad(input logic lane);
    @(posedge clk);
    bc_frame_valid[lane] <= 1'b1;
    @(posedge clk);
    bc_frame_valid[lane] <= 1'b0;
  endtask
  // downstream source asserts or releases the remote interrupt
  task automatic drive_irq(input logic v);
    @(posedge clk);
    remote_irq_in_n <= v;
  endtask
  task automatic set_link(input logic [1:0] ok, input logic [1:0] f);
    @(posedge clk);
    lane_link_ok <= ok;
    lane_fault <= f;
  endtask
endmodule

// ---- ssc_pkg.sv ----
/*
  Types shared by the sideband control modules.
  Assumes ssc_cfg.svh for all numeric constants.
*/
package ssc_pkg;
  typedef logic [7:0] ssc_byte_type;
  typedef logic [23:0] ssc_payload_type;
  typedef enum logic {SSC_IDLE, SSC_RUN} ssc_unp_state_type;
endpackage

// ---- ssc_top.sv ----
/*
  Sideband control of a two-lane serializer: port-steered register file,
  link fault status, interrupt and remote interrupt mirror, pin routing
  over forward and back channel.
  Assumes a decoded register port from the serial bus slave and frame
  fields already recovered from the serial link, all synchronous to clk.
*/
// Behaviour
// - back channel carries bus traffic, CRC and four pin bits at 5/10/20 Mbps
// - read with both targets set returns second port copy
// - duplicated write goes to every targeted port, both at once
// - common registers work whatever the target bits hold
// - second address enable reaches port two and ignores target bits
// - power down low returns every control register to default
// - any interconnect fault clears link detect bit 0 at 0x0C
// - active-low interrupt output for local and remote conditions
// - remote input falling with remote enabled drives interrupt low
// - reading interrupt status clears pending and releases output
// - mirror follows remote input level, high while unlinked
// - pin config registers steered to lane pins by 0x1E[1:0]
// - second-lane pins work only in two-lane mode
// - pin field 0x3 forward channel, 0x5 back channel
// - back-channel sampling: normal or three fast modes
`timescale 1ns/100ps
module ssc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_down_bar,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_second_addr,
  input wire logic [7:0] reg_addr,
  input wire ssc_pkg::ssc_byte_type reg_wdata,
  output ssc_pkg::ssc_byte_type reg_rdata,
  output logic reg_rvalid,
  input wire logic two_lane,
  input wire logic [1:0] lane_link_ok,
  input wire logic [1:0] lane_fault,
  input wire logic [1:0] bc_frame_valid,
  input wire logic [1:0] bc_crc_ok,
  input wire ssc_pkg::ssc_payload_type bc_payload0,
  input wire ssc_pkg::ssc_payload_type bc_payload1,
  input wire logic [2:0] bc_mode,
  input wire logic [1:0] bc_rate,
  input wire logic remote_irq_in_n,
  output logic interrupt_out_n,
  output logic remote_irq_mirror_n,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] fwd_pins
);
  import ssc_pkg::*;
  `include "ssc_cfg.svh"

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // port mask of an access; with second address enable set, second address overrides the target bits
  function automatic logic [1:0] port_mask(input ssc_byte_type psel,
                                           input logic second);
    if (psel[`SSC_PSEL_SAE]) begin
      port_mask = second ? 2'b10 : 2'b01;
    end else begin
      port_mask = psel[1:0];
    end
  endfunction

  // pin field of one port, configs packed {0x0f,0x0e,0x0d}
  function automatic logic [3:0] pin_field(input logic [23:0] c,
                                           input logic [1:0] i);
    case (i)
      2'h0: pin_field = c[3:0];
      2'h1: pin_field = c[11:8];
      2'h2: pin_field = c[15:12];
      default: pin_field = c[19:16];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // back-channel unpackers, one per lane
  // ----------------------------------------------------------------------
  ssc_bc_if bc_if[2] ();
  logic [7:0] bc_pins;

  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign bc_if[g].frame_valid = bc_frame_valid[g];
    assign bc_if[g].crc_ok = bc_crc_ok[g];
    assign bc_if[g].payload = (g == 0) ? bc_payload0 : bc_payload1;
    assign bc_if[g].mode = bc_mode;
    assign bc_if[g].rate = bc_rate;
    assign bc_pins[g*4 +: 4] = bc_if[g].pins;
    ssc_bc_unpack u_unp (
      .clk(clk),
      .resetn(resetn),
      .power_down_bar(power_down_bar),
      .bc(bc_if[g])
    );
  end

  // ----------------------------------------------------------------------
  // register file state
  // ----------------------------------------------------------------------
  ssc_byte_type psel_ff, nxt_psel;
  ssc_byte_type ictl_ff, nxt_ictl;
  logic [1:0] pend_ff, nxt_pend;
  logic [23:0] pcfg_ff [2];
  logic [23:0] nxt_pcfg [2];
  ssc_byte_type rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] wmask;
  logic rport;
  logic [1:0] link_det;
  logic link_up;
  logic rem_fall;
  logic link_drop;
  logic rin_d_ff;
  logic link_d_ff;
  logic [23:0] cfg_r;

  // a fault of any kind reads as no cable, without naming it
  assign link_det = lane_link_ok & ~lane_fault;
  assign link_up = link_det[0];
  assign wmask = port_mask(psel_ff, reg_second_addr);
  // both targets read port two, none reads port one
  assign rport = wmask[1];
  assign cfg_r = pcfg_ff[rport];
  // remote events count only on a fresh falling edge of a live link
  assign rem_fall = link_up & rin_d_ff & ~remote_irq_in_n;
  assign link_drop = link_d_ff & ~link_up;

  // register writes, pending flags and read data
  always_comb begin
    nxt_psel = psel_ff;
    nxt_ictl = ictl_ff;
    nxt_pcfg = pcfg_ff;
    nxt_pend = pend_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `SSC_ADR_PSEL: nxt_psel = reg_wdata;
        `SSC_ADR_ICTL: nxt_ictl = reg_wdata;
        `SSC_ADR_PIN0, `SSC_ADR_PIN12, `SSC_ADR_PIN3: begin
          for (int p = 0; p < 2; p++) begin
            if (wmask[p]) begin
              case (reg_addr)
                `SSC_ADR_PIN0: nxt_pcfg[p][7:0] = reg_wdata;
                `SSC_ADR_PIN12: nxt_pcfg[p][15:8] = reg_wdata;
                default: nxt_pcfg[p][23:16] = reg_wdata;
              endcase
            end
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      nxt_rvalid = 1'b1;
      case (reg_addr)
        `SSC_ADR_LINK: nxt_rdata = {7'h0, link_det[rport]};
        `SSC_ADR_PIN0: nxt_rdata = cfg_r[7:0];
        `SSC_ADR_PIN12: nxt_rdata = cfg_r[15:8];
        `SSC_ADR_PIN3: nxt_rdata = cfg_r[23:16];
        `SSC_ADR_PSEL: nxt_rdata = psel_ff;
        `SSC_ADR_BCST: nxt_rdata = {2'h0, bc_rate, 1'b0, bc_mode};
        `SSC_ADR_ICTL: nxt_rdata = ictl_ff;
        `SSC_ADR_ISTS: nxt_rdata = {2'h0, pend_ff[1], 3'h0, pend_ff[0],
                                    |pend_ff};
        default: nxt_rdata = 8'h00;
      endcase
      if (reg_addr == `SSC_ADR_ISTS) begin
        nxt_pend = 2'b00;
      end
    end
    // an event in the clearing cycle survives the clear
    if (rem_fall && ictl_ff[`SSC_ICTL_REM]) begin
      nxt_pend[1] = 1'b1;
    end
    if (link_drop && ictl_ff[`SSC_ICTL_LNK]) begin
      nxt_pend[0] = 1'b1;
    end
    if (!power_down_bar) begin
      nxt_psel = `SSC_RST_PSEL;
      nxt_ictl = `SSC_RST_ICTL;
      nxt_pcfg[0] = {3{`SSC_RST_PIN}};
      nxt_pcfg[1] = {3{`SSC_RST_PIN}};
      nxt_pend = 2'b00;
      nxt_rvalid = 1'b0;
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psel_ff <= `SSC_RST_PSEL;
      ictl_ff <= `SSC_RST_ICTL;
      pcfg_ff[0] <= {3{`SSC_RST_PIN}};
      pcfg_ff[1] <= {3{`SSC_RST_PIN}};
      pend_ff <= 2'b00;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      psel_ff <= nxt_psel;
      ictl_ff <= nxt_ictl;
      pcfg_ff <= nxt_pcfg;
      pend_ff <= nxt_pend;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ----------------------------------------------------------------------
  // interrupt and mirror outputs
  // ----------------------------------------------------------------------
  logic irq_n_ff, nxt_irq_n;
  logic mirror_ff, nxt_mirror;
  logic nxt_rin_d;
  logic nxt_link_d;

  // driven from next pending so a status read releases on the same edge
  always_comb begin
    nxt_irq_n = ~(ictl_ff[`SSC_ICTL_GLB] & |nxt_pend);
    nxt_mirror = link_up ? remote_irq_in_n : 1'b1;
    nxt_rin_d = remote_irq_in_n;
    nxt_link_d = link_up;
    if (!power_down_bar) begin
      nxt_irq_n = 1'b1;
      nxt_mirror = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_n_ff <= 1'b1;
      mirror_ff <= 1'b1;
      rin_d_ff <= 1'b1;
      link_d_ff <= 1'b0;
    end else begin
      irq_n_ff <= nxt_irq_n;
      mirror_ff <= nxt_mirror;
      rin_d_ff <= nxt_rin_d;
      link_d_ff <= nxt_link_d;
    end
  end

  assign interrupt_out_n = irq_n_ff;
  assign remote_irq_mirror_n = mirror_ff;

  // ----------------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------------
  logic [7:0] pout_ff, nxt_pout;
  logic [7:0] poe_ff, nxt_poe;
  logic [7:0] fwd_ff, nxt_fwd;

  // forward pins are sent on, back pins are driven from the unpacker;
  // the deserializer side must hold the opposite code for each pin
  always_comb begin
    nxt_pout = 8'h00;
    nxt_poe = 8'h00;
    nxt_fwd = 8'h00;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        if (p == 0 || two_lane) begin
          case (pin_field(pcfg_ff[p], 2'(i)))
            `SSC_PIN_FWD: nxt_fwd[p*4+i] = pin_in[p*4+i];
            `SSC_PIN_BACK: begin
              nxt_poe[p*4+i] = 1'b1;
              nxt_pout[p*4+i] = bc_pins[p*4+i];
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pout_ff <= 8'h00;
      poe_ff <= 8'h00;
      fwd_ff <= 8'h00;
    end else begin
      pout_ff <= nxt_pout;
      poe_ff <= nxt_poe;
      fwd_ff <= nxt_fwd;
    end
  end

  assign pin_out = pout_ff;
  assign pin_oe = poe_ff;
  assign fwd_pins = fwd_ff;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic dup_wr;
  assign dup_wr = reg_wr && power_down_bar &&
                  !psel_ff[`SSC_PSEL_SAE] && reg_addr == `SSC_ADR_PIN0;

  sequence s_ists_read;
    reg_rd && reg_addr == `SSC_ADR_ISTS && power_down_bar;
  endsequence

  sequence s_quiet;
    !rem_fall && !link_drop;
  endsequence

  a_read_releases_irq: assert property (
    s_ists_read and s_quiet |=> interrupt_out_n && !(|pend_ff))
    else $error("status read did not release interrupt");

  a_remote_irq_low: assert property (
    rem_fall && ictl_ff[`SSC_ICTL_REM] && ictl_ff[`SSC_ICTL_GLB] &&
    power_down_bar |=> !interrupt_out_n)
    else $error("remote interrupt not raised");

  a_mirror_follows: assert property (
    power_down_bar && link_up |=>
    remote_irq_mirror_n == $past(remote_irq_in_n))
    else $error("mirror does not follow remote input");

  a_mirror_unlinked: assert property (
    !link_up |=> remote_irq_mirror_n)
    else $error("mirror low without link");

  a_dup_write_both: assert property (
    dup_wr && psel_ff[1:0] == 2'b11 |=>
    pcfg_ff[0][7:0] == $past(reg_wdata) &&
    pcfg_ff[1][7:0] == $past(reg_wdata))
    else $error("dual write missed a port");

  a_no_target_hold: assert property (
    dup_wr && psel_ff[1:0] == 2'b00 |=>
    $stable(pcfg_ff[0]) && $stable(pcfg_ff[1]))
    else $error("write with no target changed a copy");

  a_read_port_two: assert property (
    reg_rd && reg_addr == `SSC_ADR_LINK && power_down_bar &&
    !psel_ff[`SSC_PSEL_SAE] && psel_ff[1:0] == 2'b11 |=>
    reg_rvalid && reg_rdata == {7'h0, $past(link_det[1])})
    else $error("dual read did not return port two");

  a_power_down_dflt: assert property (
    !power_down_bar |=> psel_ff == `SSC_RST_PSEL &&
    ictl_ff == `SSC_RST_ICTL && interrupt_out_n)
    else $error("power down left a register set");

  a_back_pin_drive: assert property (
    pcfg_ff[0][3:0] == `SSC_PIN_BACK |=> pin_oe[0])
    else $error("back channel pin not driven");

  a_lane_two_off: assert property (
    !two_lane |=> pin_oe[7:4] == 4'h0)
    else $error("second lane pin driven in one-lane mode");
endmodule

// ---- testbench.sv ----
/*
  Self-checking bench of the sideband control block.
  Assumes ssc_top and ssc_des_model on one 50 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
  import ssc_pkg::*;
  // design does not time the hold, so it is short here
  localparam int PD_HOLD = 8;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic power_down_bar = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_second_addr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  ssc_byte_type reg_wdata = 8'h00;
  logic two_lane = 1'b0;
  logic [7:0] pin_in = 8'h00;
  ssc_byte_type reg_rdata;
  logic reg_rvalid, interrupt_out_n, remote_irq_mirror_n;
  logic [7:0] pin_out, pin_oe, fwd_pins;
  logic remote_irq_in_n;
  logic [1:0] lane_link_ok, lane_fault, bc_frame_valid, bc_crc_ok, bc_rate;
  ssc_payload_type bc_payload0, bc_payload1;
  logic [2:0] bc_mode;
  int failures = 0;
  int n_compared = 0;
  // ----------
  // clock and parts
  // ----------
  always #10 clk = ~clk;
  ssc_top uut (.clk, .resetn, .power_down_bar, .reg_wr, .reg_rd,
    .reg_second_addr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .two_lane, .lane_link_ok, .lane_fault, .bc_frame_valid, .bc_crc_ok,
    .bc_payload0, .bc_payload1, .bc_mode, .bc_rate, .remote_irq_in_n,
    .interrupt_out_n, .remote_irq_mirror_n, .pin_in, .pin_out, .pin_oe,
    .fwd_pins);
  ssc_des_model des (.clk, .remote_irq_in_n, .lane_link_ok, .lane_fault,
    .bc_frame_valid, .bc_crc_ok, .bc_payload0, .bc_payload1, .bc_mode,
    .bc_rate);
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // answer stands one cycle, so it is judged in that cycle
  task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_second_addr <= s;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask
  task automatic wait_low;
    for (int i = 0; i < 4 && interrupt_out_n !== 1'b0; i++) @(posedge clk);
    #1;
    chk({7'h00, interrupt_out_n}, 8'h00);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_defaults;
    rd(8'h1e, 1'b0, 8'h01);
    rd(8'hc6, 1'b0, 8'h00);
    wr(8'h1e, 8'h03);
    wr(8'h0d, 8'h35);
    wr(8'hc6, 8'h21);
    @(posedge clk);
    power_down_bar <= 1'b0;
    repeat (PD_HOLD) @(posedge clk);
    power_down_bar <= 1'b1;
    rd(8'h1e, 1'b0, 8'h01);
    rd(8'hc6, 1'b0, 8'h00);
    rd(8'h0d, 1'b0, 8'h00);
  endtask
  task automatic t_steer;
    wr(8'h1e, 8'h03);
    wr(8'h0d, 8'h35);
    wr(8'h1e, 8'h01);
    rd(8'h0d, 1'b0, 8'h35);
    wr(8'h1e, 8'h02);
    rd(8'h0d, 1'b0, 8'h35);
    wr(8'h0d, 8'h53);
    wr(8'h1e, 8'h03);
    rd(8'h0d, 1'b0, 8'h53);
    wr(8'h1e, 8'h00);
    wr(8'h0d, 8'h11);
    rd(8'h0d, 1'b0, 8'h35);
    rd(8'h1e, 1'b0, 8'h00);
    rd(8'h55, 1'b0, 8'h00);
    wr(8'h1e, 8'h06);
    rd(8'h0d, 1'b1, 8'h53);
    rd(8'h0d, 1'b0, 8'h35);
  endtask
  task automatic t_link;
    wr(8'h1e, 8'h01);
    rd(8'h0c, 1'b0, 8'h01);
    des.set_link(2'b11, 2'b01);
    rd(8'h0c, 1'b0, 8'h00);
    des.set_link(2'b10, 2'b00);
    rd(8'h0c, 1'b0, 8'h00);
    des.set_link(2'b11, 2'b10);
    rd(8'h0c, 1'b0, 8'h01);
    wr(8'h1e, 8'h02);
    rd(8'h0c, 1'b0, 8'h00);
    wr(8'h1e, 8'h03);
    rd(8'h0c, 1'b0, 8'h00);
    des.set_link(2'b11, 2'b00);
  endtask
  task automatic t_irq;
    wr(8'hc6, 8'h03);
    des.set_link(2'b10, 2'b00);
    wait_low();
    rd(8'hc7, 1'b0, 8'h03);
    des.set_link(2'b11, 2'b00);
    wr(8'hc6, 8'h21);
    des.drive_irq(1'b0);
    wait_low();
    chk({7'h00, remote_irq_mirror_n}, 8'h00);
    rd(8'hc7, 1'b0, 8'h21);
    chk({7'h00, interrupt_out_n}, 8'h01);
    cyc(3);
    chk({7'h00, interrupt_out_n}, 8'h01);
    des.drive_irq(1'b1);
    cyc(2);
    chk({7'h00, remote_irq_mirror_n}, 8'h01);
    des.drive_irq(1'b0);
    wait_low();
    rd(8'hc7, 1'b0, 8'h21);
    des.set_link(2'b00, 2'b00);
    cyc(2);
    chk({7'h00, remote_irq_mirror_n}, 8'h01);
    des.set_link(2'b11, 2'b00);
    des.drive_irq(1'b1);
  endtask
  task automatic t_pins;
    int w;
    wr(8'h1e, 8'h01);
    wr(8'h0d, 8'h03);
    pin_in <= 8'h01;
    cyc(2);
    chk({7'h00, fwd_pins[0]}, 8'h01);
    wr(8'h0d, 8'h05);
    cyc(2);
    chk({7'h00, fwd_pins[0]}, 8'h00);
    chk({7'h00, pin_oe[0]}, 8'h01);
    for (int k = 1; k < 4; k++) begin
      w = 1 << (k - 1);
      des.set_mode(k[2:0], 2'(k - 1));
      rd(8'h1f, 1'b0, {2'b00, 2'(k - 1), 1'b0, k[2:0]});
      des.send_frame(1'b0, 24'h000001 << w);
      cyc(2);
      chk({7'h00, pin_out[0]}, 8'h00);
      cyc(40 >> (k - 1));
      chk({7'h00, pin_out[0]}, 8'h01);
    end
    des.set_mode(3'h0, 2'h2);
    des.send_frame(1'b0, 24'h000000);
    cyc(2);
    chk({7'h00, pin_out[0]}, 8'h00);
    wr(8'h1e, 8'h02);
    wr(8'h0d, 8'h05);
    cyc(2);
    chk({7'h00, pin_oe[4]}, 8'h00);
    @(posedge clk);
    two_lane <= 1'b1;
    cyc(3);
    chk({7'h00, pin_oe[4]}, 8'h01);
    chk({7'h00, pin_oe[0]}, 8'h01);
    des.send_frame(1'b1, 24'h000001);
    cyc(2);
    chk({7'h00, pin_out[4]}, 8'h01);
    des.send_bad(1'b1);
    cyc(2);
    chk({7'h00, pin_out[4]}, 8'h01);
  endtask
  // ----------
  // run control
  // ----------
  task automatic stop_test;
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_defaults();
    t_steer();
    t_link();
    t_irq();
    t_pins();
    stop_test();
  end
  // watchdog, well past the few hundred cycles the run needs
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule
